// file: scpa_regs.vh
// register offsets, field positions, reset values and timing counts for the serial config port
`ifndef SCPA_REGS_VH
`define SCPA_REGS_VH
`define SCPA_PAGE_SEL_ADDR 8'hFF
`define SCPA_PAGE_SEL_RESET 8'h00
`define SCPA_ALM_PAGE 8'h00
`define SCPA_ALM_STATUS_ADDR 8'h02
`define SCPA_ALM_NOTIFY_ADDR 8'h03
`define SCPA_ALM_MASK_ADDR 8'h04
`define SCPA_MASK_RESET 8'hFF
`define SCPA_NOTIFY_RESET 8'hFF
`define SCPA_WR_FLAG_BIT 0
`define SCPA_ADDR_LAST_BIT 5'd16
`define SCPA_FRAME_BITS 5'd24
`define SCPA_CLK_MHZ 40
`define SCPA_RC_MHZ 4
`define SCPA_RC_DIV (`SCPA_CLK_MHZ / `SCPA_RC_MHZ)
`define SCPA_RC_LAST 4'h9
`endif

// file: scpa_spi_config_port.v
// serial configuration slave with paged register port and alarm status/notify/mask
// Notes on behaviour
// - master changes data on falling edge; device samples on rising edge
// - first byte bits one to seven ignored; eighth bit 1 write, 0 read
// - second byte is the 8-bit register address
// - write: last data bit on 24th rise, commit on following fall
// - read: third byte shifts out register content, from page_select or alarm registers when addressed, else from register port
// - read data fetched after 16th rise, first bit driven next fall
// - remaining seven read bits shift out on next seven clocks
// - with select high and clock still, output holds last bit sent
// - clock toggling with select high: output low after first rise
// - status bits follow live defect level, 1 means present
// - notify sets on status rise, stays until software writes 1
// - notify can only set while its mask bit is 1
// - mask register resets to all ones
// - alarm status and notify registers run on the 4 MHz internal clock enable; mask loads on the write commit
// - interrupt is NOR of selected notify bits, high once all clear
// - write to page_select selects page; later accesses use that page
// - one address per frame, no auto increment or burst
`timescale 1ns/1ps
`include "scpa_regs.vh"

module scpa_spi_config_port #(
  parameter ALARM_W = 8
) (
  // clock and reset
  input wire CLK,
  input wire RESET_N,
  // serial link
  input wire CHIP_SELECT_BAR_PIN,
  input wire SCLK_PIN,
  input wire SDI_PIN,
  output reg SERIAL_OUT_PIN,
  // register port to the rest of the device
  output reg [7:0] REG_PAGE,
  output reg [7:0] REG_ADDR,
  output reg [7:0] REG_WDATA,
  output reg REG_EN,
  output reg REG_WR,
  input wire [7:0] REG_RDATA,
  // alarm inputs and interrupt
  input wire [ALARM_W-1:0] ALARM_DEFECT,
  input wire [ALARM_W-1:0] ALARM_IRQ_SEL,
  output reg ALARM_IRQ_N
);

  // pin synchronisers
  reg [1:0] cs_s_r;
  reg [1:0] sck_s_r;
  reg [1:0] sdi_s_r;
  reg sck_d_r;
  reg cs_d_r;
  wire cs_n = cs_s_r[1];
  wire sck_rise = sck_s_r[1] & ~sck_d_r;
  wire sck_fall = ~sck_s_r[1] & sck_d_r;
  wire cs_rise = cs_n & ~cs_d_r;

  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      cs_s_r <= 2'h3;
      sck_s_r <= 2'h0;
      sdi_s_r <= 2'h0;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      cs_s_r <= {cs_s_r[0], CHIP_SELECT_BAR_PIN};
      sck_s_r <= {sck_s_r[0], SCLK_PIN};
      sdi_s_r <= {sdi_s_r[0], SDI_PIN};
      sck_d_r <= sck_s_r[1];
      cs_d_r <= cs_s_r[1];
    end
  end

  // serial frame state
  reg [4:0] bit_cnt_r;
  reg [7:0] cmd_r;
  reg [7:0] addr_r;
  reg [7:0] data_r;
  reg [7:0] rd_sh_r;
  reg rd_load_r;
  reg wr_pend_r;
  reg idle_mute_r;
  reg [7:0] page_r;

  // alarm register state
  reg [ALARM_W-1:0] status_r;
  reg [ALARM_W-1:0] status_d_r;
  reg [ALARM_W-1:0] notify_r;
  reg [ALARM_W-1:0] mask_r;
  reg [ALARM_W-1:0] notify_clr_r;
  reg [3:0] rc_div_r;
  wire rc_tick = (rc_div_r == `SCPA_RC_LAST);

  function is_alarm;
    input [7:0] pg;
    input [7:0] ad;
    input [7:0] target;
    begin
      is_alarm = (pg == `SCPA_ALM_PAGE) && (ad == target);
    end
  endfunction

  // msb-first shift used by every byte of the frame
  function [7:0] shift_in;
    input [7:0] cur;
    input bit_in;
    begin
      shift_in = {cur[6:0], bit_in};
    end
  endfunction

  // command flag decode
  function is_write;
    input [7:0] cmd;
    begin
      is_write = cmd[`SCPA_WR_FLAG_BIT];
    end
  endfunction

  // frame phase: bounds the read window to exactly eight falls
  localparam PH_IDLE = 2'h0;
  localparam PH_HEAD = 2'h1;
  localparam PH_READ = 2'h2;
  localparam PH_DONE = 2'h3;
  reg [1:0] phase_r;
  reg [1:0] phase_nxt;
  wire last_addr_rise = sck_rise && bit_cnt_r == `SCPA_ADDR_LAST_BIT - 5'd1;
  wire last_data_rise = sck_rise && bit_cnt_r == `SCPA_FRAME_BITS - 5'd1;

  always @*
  begin
    phase_nxt = phase_r;
    // a frame cut short drops straight back to idle
    case (phase_r)
      PH_IDLE:
        if (!cs_n)
          phase_nxt = PH_HEAD;
      PH_HEAD:
        if (cs_n)
          phase_nxt = PH_IDLE;
        else if (last_addr_rise && !is_write(cmd_r))
          phase_nxt = PH_READ;
        else if (last_data_rise)
          phase_nxt = PH_DONE;
      PH_READ:
        if (cs_n)
          phase_nxt = PH_IDLE;
        else if (last_data_rise)
          phase_nxt = PH_DONE;
      PH_DONE:
        if (cs_n)
          phase_nxt = PH_IDLE;
      default:
        phase_nxt = PH_IDLE;
    endcase
  end

  // phase register
  always @(posedge CLK)
  begin
    if (!RESET_N)
      phase_r <= PH_IDLE;
    else
      phase_r <= phase_nxt;
  end

  // no shift after the 24th rise, so the last read bit stays on the pin
  reg so_nxt;
  always @*
  begin
    so_nxt = SERIAL_OUT_PIN;
    if (!cs_n && sck_fall && phase_r == PH_READ)
      so_nxt = rd_sh_r[7];
    else if (cs_n && !cs_rise && idle_mute_r && sck_rise)
      so_nxt = 1'b0;
  end

  // read multiplexer: local registers override the register port
  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = REG_RDATA;
    if (addr_r == `SCPA_PAGE_SEL_ADDR)
      rd_mux = page_r;
    else if (is_alarm(page_r, addr_r, `SCPA_ALM_STATUS_ADDR))
      rd_mux = status_r;
    else if (is_alarm(page_r, addr_r, `SCPA_ALM_NOTIFY_ADDR))
      rd_mux = notify_r;
    else if (is_alarm(page_r, addr_r, `SCPA_ALM_MASK_ADDR))
      rd_mux = mask_r;
  end

  wire commit = wr_pend_r & sck_fall & ~cs_n;
  wire [7:0] wdata_full = shift_in(data_r, sdi_s_r[1]);

  // a clear landing on a tick is kept for the next one, not lost
  reg [ALARM_W-1:0] clr_nxt;
  always @*
  begin
    clr_nxt = rc_tick ? {ALARM_W{1'b0}} : notify_clr_r;
    if (commit && is_alarm(page_r, addr_r, `SCPA_ALM_NOTIFY_ADDR))
      clr_nxt = clr_nxt | data_r[ALARM_W-1:0];
  end

  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      bit_cnt_r <= 5'h00;
      cmd_r <= 8'h00;
      addr_r <= 8'h00;
      data_r <= 8'h00;
      rd_sh_r <= 8'h00;
      rd_load_r <= 1'b0;
      wr_pend_r <= 1'b0;
      idle_mute_r <= 1'b0;
      page_r <= `SCPA_PAGE_SEL_RESET;
      SERIAL_OUT_PIN <= 1'b0;
      REG_PAGE <= `SCPA_PAGE_SEL_RESET;
      REG_ADDR <= 8'h00;
      REG_WDATA <= 8'h00;
      REG_EN <= 1'b0;
      REG_WR <= 1'b0;
      notify_clr_r <= {ALARM_W{1'b0}};
      mask_r <= {ALARM_W{1'b1}};
    end
    else
    begin
      REG_EN <= 1'b0;
      REG_WR <= 1'b0;
      REG_PAGE <= page_r;
      SERIAL_OUT_PIN <= so_nxt;
      if (cs_n)
      begin
        bit_cnt_r <= 5'h00;
        wr_pend_r <= 1'b0;
        rd_load_r <= 1'b0;
        if (cs_rise)
          idle_mute_r <= 1'b1;
        else if (idle_mute_r && sck_rise)
        begin
          idle_mute_r <= 1'b0;
        end
        // otherwise serial output holds last bit
      end
      else
      begin
        idle_mute_r <= 1'b0;
        if (sck_rise && bit_cnt_r != `SCPA_FRAME_BITS)
        begin
          bit_cnt_r <= bit_cnt_r + 5'd1;
          if (bit_cnt_r < 5'd8)
            cmd_r <= shift_in(cmd_r, sdi_s_r[1]);
          else if (bit_cnt_r < `SCPA_ADDR_LAST_BIT)
            addr_r <= shift_in(addr_r, sdi_s_r[1]);
          else
            data_r <= wdata_full;
          if (bit_cnt_r == `SCPA_ADDR_LAST_BIT - 5'd1 && !cmd_r[`SCPA_WR_FLAG_BIT])
          begin
            REG_EN <= 1'b1;
            REG_ADDR <= shift_in(addr_r, sdi_s_r[1]);
            rd_load_r <= 1'b1;
          end
          if (bit_cnt_r == `SCPA_FRAME_BITS - 5'd1 && cmd_r[`SCPA_WR_FLAG_BIT])
            wr_pend_r <= 1'b1;
        end
        if (rd_load_r)
        begin
          rd_sh_r <= rd_mux;
          rd_load_r <= 1'b0;
        end
        if (sck_fall && phase_r == PH_READ)
          rd_sh_r <= {rd_sh_r[6:0], 1'b0};
        // single register per frame, no increment
        if (commit)
        begin
          wr_pend_r <= 1'b0;
          REG_EN <= 1'b1;
          REG_WR <= 1'b1;
          REG_ADDR <= addr_r;
          REG_WDATA <= data_r;
          if (addr_r == `SCPA_PAGE_SEL_ADDR)
            page_r <= data_r;
          else if (is_alarm(page_r, addr_r, `SCPA_ALM_MASK_ADDR))
            mask_r <= data_r[ALARM_W-1:0];
        end
      end
      // clear request is held until the alarm tick consumes it
      notify_clr_r <= clr_nxt;
    end
  end

  // alarm next values; set wins over clear when both land on one tick
  reg [ALARM_W-1:0] notify_nxt;
  reg irq_n_nxt;
  always @*
  begin
    notify_nxt = notify_r;
    irq_n_nxt = ALARM_IRQ_N;
    if (rc_tick)
    begin
      notify_nxt = (notify_r & ~notify_clr_r)
        | (status_r & ~status_d_r & mask_r);
      irq_n_nxt = ~|(notify_r & ALARM_IRQ_SEL);
    end
  end

  // alarm logic on the 4 MHz enable; clears wait at most one tick
  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      rc_div_r <= 4'h0;
      status_r <= {ALARM_W{1'b0}};
      status_d_r <= {ALARM_W{1'b0}};
      notify_r <= {ALARM_W{1'b1}};
      ALARM_IRQ_N <= 1'b1;
    end
    else
    begin
      rc_div_r <= rc_tick ? 4'h0 : rc_div_r + 4'h1;
      notify_r <= notify_nxt;
      ALARM_IRQ_N <= irq_n_nxt;
      if (rc_tick)
      begin
        status_d_r <= status_r;
        status_r <= ALARM_DEFECT;
      end
    end
  end

endmodule // scpa_spi_config_port

// file: scpa_spi_config_port_asserts.sv
// pin-level assertions for the serial config port
`timescale 1ns/1ps
module scpa_spi_config_port_asserts #(parameter ALARM_W = 8) (
  // clock
  input wire CLK,
  input wire RESET_N,
  // link
  input wire CHIP_SELECT_BAR_PIN,
  input wire SCLK_PIN,
  input wire SERIAL_OUT_PIN,
  // port and alarm
  input wire REG_EN,
  input wire REG_WR,
  input wire [ALARM_W-1:0] ALARM_IRQ_SEL,
  input wire ALARM_IRQ_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // eight samples stay clear of the select sync lag
  sequence s_idle;
    CHIP_SELECT_BAR_PIN [*8];
  endsequence
  AST_WR_EN: assert property (REG_WR |-> REG_EN)
    else $error("wr without en");
  AST_EN_ONE: assert property (REG_EN |=> !REG_EN)
    else $error("en too long");
  AST_WR_FALL: assert property (REG_WR |-> !$past(SCLK_PIN, 2))
    else $error("wr not after fall");
  AST_IDLE_NO_EN: assert property (s_idle |-> !REG_EN)
    else $error("access while idle");
  AST_SO_HOLD: assert property (
    (CHIP_SELECT_BAR_PIN && $stable(SCLK_PIN)) [*8] |=> $stable(SERIAL_OUT_PIN))
    else $error("out moved");
  AST_SO_LOW: assert property (s_idle ##1 $rose(SCLK_PIN) |-> ##[1:6] !SERIAL_OUT_PIN)
    else $error("out not low");
  AST_SO_FALL: assert property (
    !CHIP_SELECT_BAR_PIN && $changed(SERIAL_OUT_PIN) |-> !$past(SCLK_PIN, 2))
    else $error("out moved off fall");
  AST_IRQ_NONE: assert property ((ALARM_IRQ_SEL == 0) [*4] |-> ALARM_IRQ_N)
    else $error("irq without select");
endmodule // scpa_spi_config_port_asserts

// file: scpa_spi_master_model.sv
// serial master that frames config port transfers
`timescale 1ns/1ps
module scpa_spi_master_model (
  // link
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire so
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // n under 24 aborts the frame early
  task automatic frame(input [23:0] w, input integer n, output [7:0] r);
    integer i;
    begin
      cs_n = 1'b0;
      #107;
      for (i = 23; i > 23 - n; i--)
      begin
        sdi = w[i];
        #100 sclk = 1'b1;
        r[i % 8] = so;
        #100 sclk = 1'b0;
      end
      #100 cs_n = 1'b1;
      sdi = ~sdi;
      #450;
    end
  endtask
  task automatic stray_clk();
    begin
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
  endtask
endmodule // scpa_spi_master_model

// file: scpa_spi_config_port_bench.sv
// self-checking bench for the serial config port
`timescale 1ns/1ps
module scpa_spi_config_port_bench;
  logic clk, reset_n;
  logic [7:0] rdata, defect, sel, rd;
  logic [15:0] lf = 16'hC043;
  logic [16:0] exp_q[$];
  wire cs_n, sclk, sdi, so, reg_en, reg_wr, irq_n;
  wire [7:0] page, addr, wdata;
  integer fail_count = 0;
  integer samples_checked = 0;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  scpa_spi_config_port DUT (.CLK(clk), .RESET_N(reset_n), .CHIP_SELECT_BAR_PIN(cs_n),
    .SCLK_PIN(sclk), .SDI_PIN(sdi), .SERIAL_OUT_PIN(so), .REG_PAGE(page),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_EN(reg_en), .REG_WR(reg_wr),
    .REG_RDATA(rdata), .ALARM_DEFECT(defect), .ALARM_IRQ_SEL(sel), .ALARM_IRQ_N(irq_n));
  scpa_spi_master_model m (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .so(so));
  function automatic [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string nm, input [16:0] seen, input [16:0] want);
    begin
      samples_checked++;
      if (seen !== want)
      begin
        fail_count++;
        $display("wrong value %s expected %h seen %h", nm, want, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checked %0d wrong %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // an empty queue pops unknown, so a stray access fails
  always @(negedge clk)
    if (reg_en === 1'b1)
      check("access", {reg_wr, addr, reg_wr ? wdata : 8'h00}, exp_q.pop_front());
  task automatic xfer(input wr, input [7:0] a, input [7:0] d, input integer n);
    begin
      lf = nx(lf);
      if (n == 24)
        exp_q.push_back({wr, a, wr ? d : 8'h00});
      m.frame({lf[7:1], wr, a, d}, n, rd);
    end
  endtask
  task automatic rd_chk(input [7:0] a, input [7:0] want);
    begin
      xfer(1'b0, a, 8'h00, 24);
      check("read", rd, want);
    end
  endtask
  initial
  begin
    reset_n = 1'b0;
    rdata = 8'h00;
    defect = 8'h00;
    sel = 8'h00;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (6) @(negedge clk);
    sel = 8'h01;
    rd_chk(8'h04, 8'hFF);
    check("irq", irq_n, 1'b0);
    xfer(1'b1, 8'h03, 8'hFF, 24);
    xfer(1'b1, 8'h04, 8'hFF, 24);
    check("irq", irq_n, 1'b1);
    rd_chk(8'h03, 8'h00);
    defect = 8'h01;
    repeat (40) @(negedge clk);
    rd_chk(8'h02, 8'h01);
    rd_chk(8'h03, 8'h01);
    check("irq", irq_n, 1'b0);
    xfer(1'b1, 8'h03, 8'h01, 24);
    xfer(1'b1, 8'h04, 8'hFE, 24);
    check("irq", irq_n, 1'b1);
    defect = 8'h00;
    repeat (40) @(negedge clk);
    defect = 8'h01;
    repeat (40) @(negedge clk);
    rd_chk(8'h03, 8'h00);
    xfer(1'b1, 8'hFF, 8'h01, 24);
    check("page", page, 8'h01);
    rdata = lf[15:8] | 8'h01;
    rd_chk(8'h10, rdata);
    check("hold", so, 1'b1);
    m.stray_clk();
    check("low", so, 1'b0);
    xfer(1'b1, 8'h20, lf[7:0], 20);
    xfer(1'b1, 8'h21, lf[15:8], 24);
    repeat (10) @(negedge clk);
    check("pending", exp_q.size(), 17'h0);
    report_and_stop;
  end
endmodule // scpa_spi_config_port_bench
bind scpa_spi_config_port scpa_spi_config_port_asserts #(.ALARM_W(ALARM_W)) u_chk (.*);
